// ---- rtl/eeprom_data_access_ctrl_regs.vh ----
`ifndef EEPROM_DATA_ACCESS_CTRL_REGS_VH
`define EEPROM_DATA_ACCESS_CTRL_REGS_VH

// Sector 0 special function register offsets
`define OFS_INDIRECT_PORT_ONE 8'h01
`define OFS_POINTER_ONE_LOW 8'h02
`define OFS_POINTER_ONE_HIGH 8'h03
`define OFS_INDIRECT_PORT_TWO 8'h04
`define OFS_POINTER_TWO_LOW 8'h05
`define OFS_POINTER_TWO_HIGH 8'h06
`define OFS_NV_ADDRESS 8'h10
`define OFS_NV_DATA 8'h11
`define OFS_IRQ_CTRL 8'h12

// Control register lives at this offset of sector 1
`define OFS_NV_CONTROL 8'h40
`define SECTOR_ONE 8'h01
`define SECTOR_ZERO 8'h00

// Control register fields
`define BIT_FETCH_TRIGGER 0
`define BIT_FETCH_PERMIT 1
`define BIT_PROGRAM_TRIGGER 2
`define BIT_PROGRAM_PERMIT 3

// Interrupt control fields
`define BIT_GLOBAL_IRQ_EN 0
`define BIT_PROGRAM_DONE_IRQ_EN 1
`define BIT_PROGRAM_DONE_FLAG 2

// Address field width and store depth
`define NV_ADDR_W 5
`define NV_DEPTH 32

// Reset values
`define RST_NV_CONTROL 4'h0
`define RST_NV_ADDRESS 5'h00
`define RST_NV_DATA 8'h00
`define RST_POINTER 8'h00
`define RST_IRQ_CTRL 3'h0

// Write cycle length in sub-clock ticks
`define NV_WRITE_TICKS 8'h40
`define NV_TICK_W 8

`endif

// ---- rtl/nv_byte_store.v ----
`timescale 1ns/1ps
`include "eeprom_data_access_ctrl_regs.vh"

module nv_byte_store (
  input wire mclk,
  input wire ce,
  input wire we,
  input wire [`NV_ADDR_W-1:0] waddr,
  input wire [7:0] wdata,
  input wire re,
  input wire [`NV_ADDR_W-1:0] raddr,
  output reg [7:0] rdata
);

  reg [7:0] mem [0:`NV_DEPTH-1];

  // Storage holds its contents through reset
  always @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      if (re) begin
        rdata <= mem[raddr];
      end
    end
  end

endmodule

// ---- rtl/nv_write_timer.v ----
`timescale 1ns/1ps
`include "eeprom_data_access_ctrl_regs.vh"

module nv_write_timer (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire start,
  input wire sub_tick,
  output reg busy,
  output reg done
);

  reg [`NV_TICK_W-1:0] cnt_q;

  // Counts sub-clock ticks, so length in mclk cycles varies
  always @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q <= {`NV_TICK_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt_q <= `NV_WRITE_TICKS;
      end else if (busy && sub_tick) begin
        if (cnt_q == {{(`NV_TICK_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
          cnt_q <= {`NV_TICK_W{1'b0}};
        end else begin
          cnt_q <= cnt_q - {{(`NV_TICK_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ---- rtl/eeprom_data_access_ctrl.v ----
// Functional notes
// RULE1: Store of 32 bytes, one byte per access
// RULE2: Address register five bits, upper bits zero
// RULE3: Software reaches control through pointer and port
// RULE4: Program permit gates every write cycle
// RULE5: Program trigger starts write, clears when done
// RULE6: Program trigger ignored unless permit set earlier
// RULE7: Fetch permit gates every read cycle
// RULE8: Fetch trigger reads byte, then clears itself
// RULE9: Fetch trigger ignored unless permit set earlier
// RULE10: Fetched byte held until next operation
// RULE11: Software never sets both triggers together
// RULE12: Software sets permit, then trigger next cycle
// RULE13: Software masks global interrupt around write start
// RULE14: Write timed by asynchronous internal sub-clock timer; the timer here is clocked by mclk and counts sub_tick
// RULE15: Software ensures sub-clock stable before writing
// RULE16: Software leaves registers alone during write
// RULE17: Reset clears control bits and pointer highs
// RULE18: Write end always sets done flag
// RULE19: Flag, enables, stack room raise vector request
// RULE20: Service clears done flag and global enable
// RULE21: Control upper nibble zero, low nibble resets
// RULE22: Software rewrites address for every read
// RULE23: Software avoids sleep during store cycles
// RULE24: Busy ignores triggers, keeps address data latched
`timescale 1ns/1ps
`include "eeprom_data_access_ctrl_regs.vh"

module eeprom_data_access_ctrl (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire sub_tick,
  input wire stack_full,
  input wire irq_ack,
  output wire irq_req,
  output wire global_irq_en,
  output wire busy
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_RD_ISSUE = 4'b0010;
  localparam ST_RD_LOAD = 4'b0100;
  localparam ST_WR_WAIT = 4'b1000;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [3:0] ctrl_q;
  reg [3:0] ctrl_d;
  reg [`NV_ADDR_W-1:0] addr_q;
  reg [7:0] data_q;
  reg [7:0] data_d;
  reg [7:0] p1_low_q;
  reg [7:0] p1_high_q;
  reg [7:0] p2_low_q;
  reg [7:0] p2_high_q;
  reg [`NV_ADDR_W-1:0] lat_addr_q;
  reg [7:0] lat_data_q;
  reg [2:0] irq_q;
  reg [2:0] irq_d;
  reg [7:0] tgt_sector;
  reg [7:0] tgt_offset;
  reg tgt_valid;
  reg [7:0] rd_value;
  reg start_rd;
  reg start_wr;
  reg mem_re;
  reg mem_we;
  wire [7:0] mem_rdata;
  wire tmr_done;
  wire acc_ctrl_wr;
  wire acc_addr_wr;
  wire acc_data_wr;
  wire acc_irq_wr;
  wire wr_go;
  wire rd_go;

  // Resolve a direct or indirect access into sector and offset
  always @* begin
    tgt_sector = `SECTOR_ZERO;
    tgt_offset = sfr_addr;
    tgt_valid = 1'b1;
    if (sfr_addr == `OFS_INDIRECT_PORT_ONE) begin
      tgt_sector = p1_high_q;
      tgt_offset = p1_low_q;
    end else if (sfr_addr == `OFS_INDIRECT_PORT_TWO) begin
      tgt_sector = p2_high_q;
      tgt_offset = p2_low_q;
    end
    if ((sfr_addr == `OFS_INDIRECT_PORT_ONE) || (sfr_addr == `OFS_INDIRECT_PORT_TWO)) begin
      if ((tgt_sector == `SECTOR_ZERO) &&
          ((tgt_offset == `OFS_INDIRECT_PORT_ONE) ||
           (tgt_offset == `OFS_INDIRECT_PORT_TWO))) begin
        tgt_valid = 1'b0;
      end
    end
  end

  // RULE3 control reached only in sector one
  assign acc_ctrl_wr = sfr_wr && tgt_valid && (tgt_sector == `SECTOR_ONE) &&
                       (tgt_offset == `OFS_NV_CONTROL);
  assign acc_addr_wr = sfr_wr && tgt_valid && (tgt_sector == `SECTOR_ZERO) &&
                       (tgt_offset == `OFS_NV_ADDRESS);
  assign acc_data_wr = sfr_wr && tgt_valid && (tgt_sector == `SECTOR_ZERO) &&
                       (tgt_offset == `OFS_NV_DATA);
  assign acc_irq_wr = sfr_wr && tgt_valid && (tgt_sector == `SECTOR_ZERO) &&
                      (tgt_offset == `OFS_IRQ_CTRL);

  // RULE4 RULE6 write needs permit already stored
  assign wr_go = acc_ctrl_wr && sfr_wdata[`BIT_PROGRAM_TRIGGER] &&
                 ctrl_q[`BIT_PROGRAM_PERMIT];
  // RULE7 RULE9 read needs permit already stored
  assign rd_go = acc_ctrl_wr && sfr_wdata[`BIT_FETCH_TRIGGER] &&
                 ctrl_q[`BIT_FETCH_PERMIT] && !sfr_wdata[`BIT_PROGRAM_TRIGGER];

  // Sequencer
  always @* begin
    st_d = st_q;
    start_rd = 1'b0;
    start_wr = 1'b0;
    mem_re = 1'b0;
    mem_we = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // RULE24 triggers taken only while idle
        if (wr_go) begin
          start_wr = 1'b1;
          st_d = ST_WR_WAIT;
        end else if (rd_go) begin
          start_rd = 1'b1;
          st_d = ST_RD_ISSUE;
        end
      end
      ST_RD_ISSUE: begin
        mem_re = 1'b1;
        st_d = ST_RD_LOAD;
      end
      ST_RD_LOAD: begin
        st_d = ST_IDLE;
      end
      ST_WR_WAIT: begin
        // RULE14 end set by sub-clock timer
        if (tmr_done) begin
          mem_we = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Control register next value
  always @* begin
    ctrl_d = ctrl_q;
    if (acc_ctrl_wr) begin
      ctrl_d[`BIT_PROGRAM_PERMIT] = sfr_wdata[`BIT_PROGRAM_PERMIT];
      ctrl_d[`BIT_FETCH_PERMIT] = sfr_wdata[`BIT_FETCH_PERMIT];
    end
    // RULE5 program trigger held as busy
    if (start_wr) begin
      ctrl_d[`BIT_PROGRAM_TRIGGER] = 1'b1;
    end
    // RULE8 fetch trigger held during read
    if (start_rd) begin
      ctrl_d[`BIT_FETCH_TRIGGER] = 1'b1;
    end
    // RULE5 self clear at write end
    if ((st_q == ST_WR_WAIT) && tmr_done) begin
      ctrl_d[`BIT_PROGRAM_TRIGGER] = 1'b0;
    end
    // RULE8 self clear at read end
    if (st_q == ST_RD_LOAD) begin
      ctrl_d[`BIT_FETCH_TRIGGER] = 1'b0;
    end
  end

  // Data register next value
  always @* begin
    data_d = data_q;
    if (acc_data_wr) begin
      data_d = sfr_wdata;
    end
    // RULE8 RULE10 fetched byte loaded once, then held
    if (st_q == ST_RD_LOAD) begin
      data_d = mem_rdata;
    end
  end

  // Interrupt control next value
  always @* begin
    irq_d = irq_q;
    if (acc_irq_wr) begin
      irq_d = sfr_wdata[2:0];
    end
    // RULE20 service clears flag and global enable
    if (irq_ack) begin
      irq_d[`BIT_PROGRAM_DONE_FLAG] = 1'b0;
      irq_d[`BIT_GLOBAL_IRQ_EN] = 1'b0;
    end
    // RULE18 done flag set wins over clear
    if ((st_q == ST_WR_WAIT) && tmr_done) begin
      irq_d[`BIT_PROGRAM_DONE_FLAG] = 1'b1;
    end
  end

  // Register file and state
  always @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      // RULE17 RULE21 control and pointers cleared
      ctrl_q <= `RST_NV_CONTROL;
      p1_high_q <= `RST_POINTER;
      p2_high_q <= `RST_POINTER;
      p1_low_q <= `RST_POINTER;
      p2_low_q <= `RST_POINTER;
      addr_q <= `RST_NV_ADDRESS;
      data_q <= `RST_NV_DATA;
      lat_addr_q <= `RST_NV_ADDRESS;
      lat_data_q <= `RST_NV_DATA;
      irq_q <= `RST_IRQ_CTRL;
    end else if (ce) begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      irq_q <= irq_d;
      // RULE2 only five address bits kept
      if (acc_addr_wr) begin
        addr_q <= sfr_wdata[`NV_ADDR_W-1:0];
      end
      if (sfr_wr && (sfr_addr == `OFS_POINTER_ONE_LOW)) begin
        p1_low_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == `OFS_POINTER_ONE_HIGH)) begin
        p1_high_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == `OFS_POINTER_TWO_LOW)) begin
        p2_low_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == `OFS_POINTER_TWO_HIGH)) begin
        p2_high_q <= sfr_wdata;
      end
      // RULE24 address and data latched at start
      if (start_wr || start_rd) begin
        lat_addr_q <= acc_addr_wr ? sfr_wdata[`NV_ADDR_W-1:0] : addr_q;
        lat_data_q <= acc_data_wr ? sfr_wdata : data_q;
      end
    end
  end

  // Read multiplexer
  always @* begin
    rd_value = 8'h00;
    if (tgt_valid) begin
      if (tgt_sector == `SECTOR_ONE) begin
        // RULE21 upper nibble reads zero
        if (tgt_offset == `OFS_NV_CONTROL) begin
          rd_value = {4'h0, ctrl_q};
        end
      end else if (tgt_sector == `SECTOR_ZERO) begin
        case (tgt_offset)
          `OFS_POINTER_ONE_LOW: begin
            rd_value = p1_low_q;
          end
          `OFS_POINTER_ONE_HIGH: begin
            rd_value = p1_high_q;
          end
          `OFS_POINTER_TWO_LOW: begin
            rd_value = p2_low_q;
          end
          `OFS_POINTER_TWO_HIGH: begin
            rd_value = p2_high_q;
          end
          // RULE2 upper address bits read zero
          `OFS_NV_ADDRESS: begin
            rd_value = {3'h0, addr_q};
          end
          `OFS_NV_DATA: begin
            rd_value = data_q;
          end
          `OFS_IRQ_CTRL: begin
            rd_value = {5'h00, irq_q};
          end
          default: begin
            rd_value = 8'h00;
          end
        endcase
      end
    end
  end

  // Read data registered one cycle after the strobe
  always @(posedge mclk) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (ce) begin
      if (sfr_rd) begin
        sfr_rdata <= rd_value;
      end
    end
  end

  // RULE19 vector request when flag and enables set and stack not full
  assign irq_req = irq_q[`BIT_PROGRAM_DONE_FLAG] && irq_q[`BIT_PROGRAM_DONE_IRQ_EN] &&
                   irq_q[`BIT_GLOBAL_IRQ_EN] && !stack_full;
  assign global_irq_en = irq_q[`BIT_GLOBAL_IRQ_EN];
  assign busy = !st_q[0];

  // RULE14 write timer, clocked by mclk, counts sub_tick pulses
  nv_write_timer u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .start(start_wr),
    .sub_tick(sub_tick),
    .busy(),
    .done(tmr_done)
  );

  // RULE1 single byte store access
  nv_byte_store u_store (
    .mclk(mclk),
    .ce(ce),
    .we(mem_we),
    .waddr(lat_addr_q),
    .wdata(lat_data_q),
    .re(mem_re),
    .raddr(lat_addr_q),
    .rdata(mem_rdata)
  );

endmodule

// ---- testbench/nv_ctrl_properties.sv ----
`timescale 1ns/1ps
module nv_ctrl_checker (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire sub_tick,
  input wire stack_full,
  input wire irq_ack,
  input wire irq_req,
  input wire global_irq_en,
  input wire busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_reset_idle: assert property (disable iff (1'b0) !rst_b |=>
    !busy && !irq_req && !global_irq_en && sfr_rdata == 8'h00)
    else $error("outputs not idle after reset");
  chk_irq_enables: assert property (irq_req |-> global_irq_en)
    else $error("request without global enable");
  chk_stack_blocks: assert property (stack_full |-> !irq_req)
    else $error("request while stack full");
  chk_ack_clears: assert property (ce && irq_ack |=> !global_irq_en && !irq_req)
    else $error("service did not clear enable");
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  chk_busy_min: assert property ($rose(busy) |-> busy[*2])
    else $error("cycle shorter than two clocks");
  chk_busy_cause: assert property ($rose(busy) |-> $past(sfr_wr) &&
    ($past(sfr_addr) == 8'h01 || $past(sfr_addr) == 8'h04))
    else $error("cycle began without control write");
  chk_global_cause: assert property ($rose(global_irq_en) |->
    $past(sfr_wr) && $past(sfr_addr) == 8'h12)
    else $error("global enable set without write");
  cover property ($rose(irq_req));
  cover property ($rose(busy));
  cover property (irq_ack && irq_req);
endmodule

bind eeprom_data_access_ctrl nv_ctrl_checker chk_u (.mclk(mclk), .rst_b(rst_b), .ce(ce),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sub_tick(sub_tick), .stack_full(stack_full), .irq_ack(irq_ack),
  .irq_req(irq_req), .global_irq_en(global_irq_en), .busy(busy));

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "eeprom_data_access_ctrl_regs.vh"
module tb_top;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg ce = 1'b1;
  reg [7:0] sfr_addr = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg [7:0] sfr_wdata = 8'h00;
  reg sub_tick = 1'b0;
  reg stack_full = 1'b0;
  reg irq_ack = 1'b0;
  wire [7:0] sfr_rdata;
  wire irq_req;
  wire global_irq_en;
  wire busy;
  integer failures = 0;
  integer checks = 0;
  integer cycles = 0;

  eeprom_data_access_ctrl dut_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sub_tick(sub_tick), .stack_full(stack_full), .irq_ack(irq_ack), .irq_req(irq_req),
    .global_irq_en(global_irq_en), .busy(busy));

  always #4 mclk = ~mclk;

  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // sub-clock stable from start
  // Sub-clock tick every other cycle, plus the hang limit
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    sub_tick <= #1 ~sub_tick;
    if (cycles == 4000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  task step;
    begin
      @(posedge mclk);
      #1;
    end
  endtask

  task chk(input [8*8:1] nm, input [7:0] e, input [7:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_rd = 1'b0;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      step;
    end
  endtask

  task idle;
    begin
      sfr_wr = 1'b0;
      step;
    end
  endtask

  task rd(input [7:0] a, input [7:0] e, input [8*8:1] nm);
    begin
      sfr_wr = 1'b0;
      sfr_addr = a;
      sfr_rd = 1'b1;
      step;
      chk(nm, e, sfr_rdata);
      sfr_rd = 1'b0;
      step;
    end
  endtask

  task wait_idle;
    integer n;
    begin
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
        step;
        n = n + 1;
      end
      chk("timeout", 8'h00, {7'h00, busy});
    end
  endtask

  task t_reset;
    begin
      rd(`OFS_NV_ADDRESS, 8'h00, "address");
      rd(`OFS_NV_DATA, 8'h00, "data");
      rd(`OFS_IRQ_CTRL, 8'h00, "irqctrl");
      rd(`OFS_POINTER_ONE_HIGH, 8'h00, "ptrhigh");
      rd(`OFS_INDIRECT_PORT_ONE, 8'h00, "sector0");
      wr(`OFS_POINTER_ONE_HIGH, `SECTOR_ONE);
      wr(`OFS_POINTER_ONE_LOW, `OFS_NV_CONTROL);
      wr(8'h20, 8'h5A);
      idle;
      rd(`OFS_INDIRECT_PORT_ONE, 8'h00, "control");
      rd(8'h20, 8'h00, "unmapped");
      $display("test reset done");
    end
  endtask

  task t_refuse;
    begin
      wr(`OFS_NV_ADDRESS, 8'hFF);
      wr(`OFS_INDIRECT_PORT_ONE, 8'hF1);
      idle;
      chk("busy", 8'h00, {7'h00, busy});
      rd(`OFS_NV_ADDRESS, 8'h1F, "address");
      rd(`OFS_INDIRECT_PORT_ONE, 8'h00, "control");
      wr(`OFS_INDIRECT_PORT_ONE, 8'h04);
      idle;
      chk("busy", 8'h00, {7'h00, busy});
      wr(`OFS_INDIRECT_PORT_ONE, 8'h0C);
      idle;
      chk("busy", 8'h00, {7'h00, busy});
      rd(`OFS_INDIRECT_PORT_ONE, 8'h08, "control");
      wr(`OFS_INDIRECT_PORT_ONE, 8'h03);
      idle;
      chk("busy", 8'h00, {7'h00, busy});
      rd(`OFS_INDIRECT_PORT_ONE, 8'h02, "control");
      wr(`OFS_INDIRECT_PORT_ONE, 8'h00);
      idle;
      $display("test refuse done");
    end
  endtask

  task t_write;
    begin
      wr(`OFS_IRQ_CTRL, 8'h02);
      wr(`OFS_NV_ADDRESS, 8'h1F);
      wr(`OFS_NV_DATA, 8'hA5);
      wr(`OFS_INDIRECT_PORT_ONE, 8'h08);
      wr(`OFS_INDIRECT_PORT_ONE, 8'h0C);
      wr(`OFS_IRQ_CTRL, 8'h03);
      idle;
      chk("busy", 8'h01, {7'h00, busy});
      rd(`OFS_INDIRECT_PORT_ONE, 8'h0C, "control");
      stack_full = 1'b1;
      wait_idle;
      step;
      chk("irqfull", 8'h00, {7'h00, irq_req});
      stack_full = 1'b0;
      step;
      chk("irqreq", 8'h01, {7'h00, irq_req});
      rd(`OFS_IRQ_CTRL, 8'h07, "irqctrl");
      rd(`OFS_INDIRECT_PORT_ONE, 8'h08, "control");
      irq_ack = 1'b1;
      step;
      irq_ack = 1'b0;
      rd(`OFS_IRQ_CTRL, 8'h02, "irqctrl");
      $display("test write done");
    end
  endtask

  task t_read;
    begin
      wr(`OFS_POINTER_TWO_HIGH, `SECTOR_ONE);
      wr(`OFS_POINTER_TWO_LOW, `OFS_NV_CONTROL);
      wr(`OFS_INDIRECT_PORT_TWO, 8'h00);
      wr(`OFS_NV_DATA, 8'h00);
      wr(`OFS_NV_ADDRESS, 8'h1F);
      wr(`OFS_INDIRECT_PORT_TWO, 8'h02);
      wr(`OFS_INDIRECT_PORT_TWO, 8'h03);
      idle;
      chk("busy", 8'h01, {7'h00, busy});
      wait_idle;
      rd(`OFS_NV_DATA, 8'hA5, "data");
      rd(`OFS_INDIRECT_PORT_TWO, 8'h02, "control");
      rd(`OFS_NV_DATA, 8'hA5, "data");
      $display("test read done");
    end
  endtask

  task t_rearm;
    begin
      wr(`OFS_INDIRECT_PORT_TWO, 8'h0A);
      rd(`OFS_INDIRECT_PORT_TWO, 8'h0A, "control");
      rst_b = 1'b0;
      step;
      step;
      rst_b = 1'b1;
      rd(`OFS_POINTER_TWO_HIGH, 8'h00, "ptrhigh");
      rd(`OFS_NV_DATA, 8'h00, "data");
      wr(`OFS_POINTER_TWO_HIGH, `SECTOR_ONE);
      wr(`OFS_POINTER_TWO_LOW, `OFS_NV_CONTROL);
      rd(`OFS_INDIRECT_PORT_TWO, 8'h00, "control");
      $display("test rearm done");
    end
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_reset;
    t_refuse;
    t_write;
    t_read;
    t_rearm;
    print_verdict;
  end
endmodule
